/* core/pgm_top.sv */
// port g upper pin function mux with classic wishbone register slave
//
// The placing of the registers and the Wishbone interface to the registers were decided locally.
`timescale 1ns/1ns
module pgm_top (
  input  wire logic        CORE_CLK,         // system clock, 100 MHz
  input  wire logic        RESETN,           // synchronous reset, active low
  input  wire logic [7:0]  WB_ADR_I,         // byte address
  input  wire logic [31:0] WB_DAT_I,         // write data, low byte used
  output logic      [31:0] WB_DAT_O,         // read data
  input  wire logic        WB_WE_I,          // write enable
  input  wire logic [3:0]  WB_SEL_I,         // byte lanes
  input  wire logic        WB_CYC_I,         // cycle
  input  wire logic        WB_STB_I,         // strobe
  output logic             WB_ACK_O,         // acknowledge
  input  wire logic [5:2]  PIN_IN,           // pin input levels
  output logic      [5:2]  PIN_OUT,          // pin output levels
  output logic      [5:2]  PIN_OE_N,         // pin drive enable, low drives
  input  wire logic        SER_SYNC_TX_EN,   // serial synchronous transmit active
  input  wire logic        SER_SYNC_DATA,    // serial synchronous data out
  input  wire logic        CMP_FOUR_EN,      // compare unit four output active
  input  wire logic        CMP_FOUR_OUT,     // compare unit four output
  input  wire logic        CMP_FIVE_EN,      // compare unit five output active
  input  wire logic        CMP_FIVE_OUT,     // compare unit five output
  input  wire logic        EPWM_THREE_D_EN,  // enhanced pwm three d active
  input  wire logic        EPWM_THREE_D,     // enhanced pwm three d
  input  wire logic        EPWM_ONE_D_EN,    // enhanced pwm one d active
  input  wire logic        EPWM_ONE_D,       // enhanced pwm one d
  input  wire logic        EPWM_SHUTDOWN,    // enhanced pwm shutdown event
  input  wire logic        CLOCK_CAL_EN,     // clock-calendar output active
  input  wire logic        CLOCK_CAL_OUT,    // clock-calendar output
  output logic             SER_ASYNC_RX,     // serial receive data
  output logic             CMP_FOUR_CAPTURE, // capture input four
  output logic             CMP_FIVE_CAPTURE, // capture input five
  output logic             TIMER_SEVEN_CLK,  // timer seven clock input
  output logic             TIMER_FIVE_GATE,  // timer five gate input
  output logic      [4:2]  ANALOG_SEL        // pin is analog channel
);
  typedef struct packed {
    logic       ack;
    logic [7:0] dat;
    logic [4:2] lat;
    logic [4:2] dir;
    logic [7:0] ana_sel;
    logic [7:0] od_one;
    logic [7:0] od_two;
    logic [7:0] od_three;
    logic [2:0] ctrl;
    logic       rx;
    logic       cap_four;
    logic       cap_five;
    logic       tmr_clk;
    logic       tmr_gate;
  } pgm_top_state_type;

  localparam pgm_top_state_type ST_RESET = '{
    ack:      1'b0,
    dat:      8'h00,
    lat:      pgm_pkg::RST_LATCH,
    dir:      pgm_pkg::RST_DIRECTION,
    ana_sel:  pgm_pkg::RST_ANALOG_SELECT,
    od_one:   pgm_pkg::RST_OD,
    od_two:   pgm_pkg::RST_OD,
    od_three: pgm_pkg::RST_OD,
    ctrl:     pgm_pkg::RST_CONTROL,
    rx:       1'b0,
    cap_four: 1'b0,
    cap_five: 1'b0,
    tmr_clk:  1'b0,
    tmr_gate: 1'b0
  };

  function automatic logic reg_hit(input logic [7:0] adr, input logic [7:0] off);
    return adr[7:2] == off[7:2];
  endfunction

  pgm_top_state_type st_r;
  pgm_top_state_type st_nxt;
  logic [5:2]        pin_lvl;
  logic [4:2]        ana_mask;
  logic [4:2]        dig;
  logic              pin_five;
  logic              req;
  logic              wr;
  logic [7:0]        wdat;
  logic [7:0]        rd_byte;

  // ==========================================
  // pin input path and output mux
  pgm_sync u_sync (
    .clk    (CORE_CLK),
    .resetn (RESETN),
    .d      (PIN_IN),
    .q      (pin_lvl)
  );

  pgm_pin_if pin_bus ();

  assign pin_bus.lat           = st_r.lat;
  assign pin_bus.dir           = st_r.dir;
  assign pin_bus.od_serial     = st_r.od_three[pgm_pkg::POS_SERIAL_TWO_OD];
  assign pin_bus.od_cmp_four   = st_r.od_two[pgm_pkg::POS_COMPARE_FOUR_OD];
  assign pin_bus.od_cmp_five   = st_r.od_two[pgm_pkg::POS_COMPARE_FIVE_OD];
  assign pin_bus.tri_pwm_three = st_r.ctrl[pgm_pkg::POS_PWM_THREE_TRI];
  assign pin_bus.tri_pwm_one   = st_r.ctrl[pgm_pkg::POS_PWM_ONE_TRI];

  pgm_pin_mux u_mux (
    .clk           (CORE_CLK),
    .resetn        (RESETN),
    .pif           (pin_bus.mux),
    .ser_sync_en   (SER_SYNC_TX_EN),
    .ser_sync_data (SER_SYNC_DATA),
    .cmp_four_en   (CMP_FOUR_EN),
    .cmp_four      (CMP_FOUR_OUT),
    .cmp_five_en   (CMP_FIVE_EN),
    .cmp_five      (CMP_FIVE_OUT),
    .pwm_three_en  (EPWM_THREE_D_EN),
    .pwm_three     (EPWM_THREE_D),
    .pwm_one_en    (EPWM_ONE_D_EN),
    .pwm_one       (EPWM_ONE_D),
    .pwm_shutdown  (EPWM_SHUTDOWN),
    .cal_en        (CLOCK_CAL_EN),
    .cal_out       (CLOCK_CAL_OUT)
  );

  // analog select only masks the digital input, never the driver
  assign ana_mask = {st_r.ana_sel[pgm_pkg::POS_ANALOG_SIXTEEN],
                     st_r.ana_sel[pgm_pkg::POS_ANALOG_SEVENTEEN],
                     st_r.ana_sel[pgm_pkg::POS_ANALOG_EIGHTEEN]};
  assign dig      = pin_lvl[4:2] & ~ana_mask;
  // bit five only while master clear is off
  assign pin_five = pin_lvl[pgm_pkg::POS_PIN_FIVE] && !st_r.ctrl[pgm_pkg::POS_MASTER_CLEAR_EN];

  // ==========================================
  // wishbone slave: ack one cycle after request, write lands on the ack edge
  assign req  = WB_CYC_I && WB_STB_I;
  assign wr   = req && st_r.ack && WB_WE_I && WB_SEL_I[0];
  assign wdat = WB_DAT_I[7:0];

  // unimplemented bits read zero; unmapped reads give zero
  always_comb begin
    case (WB_ADR_I[7:2])
      pgm_pkg::OFF_PIN_LEVELS[7:2]:    rd_byte = {2'h0, pin_five, dig, 2'h0};
      pgm_pkg::OFF_DIRECTION[7:2]:     rd_byte = {3'h0, st_r.dir, 2'h0};
      pgm_pkg::OFF_OUTPUT_LATCH[7:2]:  rd_byte = {3'h0, st_r.lat, 2'h0};
      pgm_pkg::OFF_ANALOG_SELECT[7:2]: rd_byte = st_r.ana_sel;
      pgm_pkg::OFF_OD_ONE[7:2]:        rd_byte = st_r.od_one;
      pgm_pkg::OFF_OD_TWO[7:2]:        rd_byte = st_r.od_two;
      pgm_pkg::OFF_OD_THREE[7:2]:      rd_byte = st_r.od_three;
      pgm_pkg::OFF_CONTROL[7:2]:       rd_byte = {5'h00, st_r.ctrl};
      default:                         rd_byte = 8'h00;
    endcase
  end

  always_comb begin
    st_nxt     = st_r;
    st_nxt.ack = req && !st_r.ack;
    if (req && !st_r.ack) begin
      st_nxt.dat = rd_byte;
    end
    if (wr) begin
      if (reg_hit(WB_ADR_I, pgm_pkg::OFF_PIN_LEVELS) || reg_hit(WB_ADR_I, pgm_pkg::OFF_OUTPUT_LATCH)) begin
        st_nxt.lat = wdat[4:2];
      end
      if (reg_hit(WB_ADR_I, pgm_pkg::OFF_DIRECTION)) begin
        st_nxt.dir = wdat[4:2];
      end
      if (reg_hit(WB_ADR_I, pgm_pkg::OFF_ANALOG_SELECT)) begin
        st_nxt.ana_sel = wdat;
      end
      if (reg_hit(WB_ADR_I, pgm_pkg::OFF_OD_ONE)) begin
        st_nxt.od_one = wdat & pgm_pkg::MASK_OD_ONE;
      end
      if (reg_hit(WB_ADR_I, pgm_pkg::OFF_OD_TWO)) begin
        st_nxt.od_two = wdat & pgm_pkg::MASK_OD_TWO;
      end
      if (reg_hit(WB_ADR_I, pgm_pkg::OFF_OD_THREE)) begin
        st_nxt.od_three = wdat & pgm_pkg::MASK_OD_THREE;
      end
      if (reg_hit(WB_ADR_I, pgm_pkg::OFF_CONTROL)) begin
        st_nxt.ctrl = wdat[2:0];
      end
    end
    // receive data when pin two is input; relies on software setting it
    st_nxt.rx       = st_r.dir[2] && dig[2];
    // capture path when direction is 1
    st_nxt.cap_four = st_r.dir[3] && dig[3];
    st_nxt.cap_five = st_r.dir[4] && dig[4];
    st_nxt.tmr_clk  = dig[4];
    st_nxt.tmr_gate = dig[4];
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      st_r <= ST_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================
  // outputs
  assign WB_ACK_O         = st_r.ack;
  assign WB_DAT_O         = {24'h000000, st_r.dat};
  assign PIN_OUT          = pin_bus.pin_out;
  assign PIN_OE_N         = pin_bus.pin_oe_n;
  assign SER_ASYNC_RX     = st_r.rx;
  assign CMP_FOUR_CAPTURE = st_r.cap_four;
  assign CMP_FIVE_CAPTURE = st_r.cap_five;
  assign TIMER_SEVEN_CLK  = st_r.tmr_clk;
  assign TIMER_FIVE_GATE  = st_r.tmr_gate;
  assign ANALOG_SEL       = ana_mask;

  // ==========================================
  // checks
  logic rd_ack;
  logic wr_dir;
  logic wr_port;
  assign rd_ack  = WB_ACK_O && req && !WB_WE_I;
  assign wr_dir  = wr && reg_hit(WB_ADR_I, pgm_pkg::OFF_DIRECTION);
  assign wr_port = wr && reg_hit(WB_ADR_I, pgm_pkg::OFF_PIN_LEVELS);

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);

  rx_follows_pin_a: assert property (st_r.dir[2] && !ana_mask[2] |=> SER_ASYNC_RX == $past(pin_lvl[2]))
    else $error("receive data does not follow pin two");
  analog_reset_a: assert property (!$past(RESETN) |-> ANALOG_SEL == 3'h7 && st_r.ana_sel == 8'hff)
    else $error("analog select not set after reset");
  dir_read_zero_a: assert property (rd_ack && reg_hit(WB_ADR_I, pgm_pkg::OFF_DIRECTION)
                                    |-> WB_DAT_O[31:5] == 27'h0 && WB_DAT_O[1:0] == 2'h0)
    else $error("unimplemented direction bits not zero");
  od_unimpl_a: assert property (st_r.od_one[4:1] == 4'h0 && st_r.od_three[5:1] == 5'h00)
    else $error("unimplemented open-drain bits set");
  pin_five_gone_a: assert property (rd_ack && reg_hit(WB_ADR_I, pgm_pkg::OFF_PIN_LEVELS)
                                    && st_r.ctrl[0] |-> WB_DAT_O[5] == 1'b0)
    else $error("bit five read while master clear enabled");
  // a reset reloads the direction without a write, so the edge after it is skipped
  dir_no_override_a: assert property ($past(RESETN) && !$past(wr_dir) |-> $stable(st_r.dir))
    else $error("direction changed without a write");
  latch_write_a: assert property (wr_port |=> st_r.lat == $past(WB_DAT_I[4:2]) ##1 !WB_ACK_O)
    else $error("port write did not load latch");

  // ==========================================
  // bus timing, register contents and input paths
  // one ack per request, never two in a row
  ack_answer_a: assert property (req && !WB_ACK_O |=> WB_ACK_O)
    else $error("request not acknowledged");
  ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("acknowledge held for two cycles");
  // pins 0, 1 and the upper bytes are not implemented
  rd_high_zero_a: assert property (WB_ACK_O |-> WB_DAT_O[31:8] == 24'h000000)
    else $error("read data upper bytes not zero");
  port_read_zero_a: assert property (rd_ack && reg_hit(WB_ADR_I, pgm_pkg::OFF_PIN_LEVELS)
                                     |-> WB_DAT_O[7:6] == 2'h0 && WB_DAT_O[1:0] == 2'h0)
    else $error("unimplemented port bits not zero");
  lat_read_zero_a: assert property (rd_ack && reg_hit(WB_ADR_I, pgm_pkg::OFF_OUTPUT_LATCH)
                                    |-> WB_DAT_O[7:5] == 3'h0 && WB_DAT_O[1:0] == 2'h0)
    else $error("unimplemented latch bits not zero");
  dir_read_a: assert property (rd_ack && reg_hit(WB_ADR_I, pgm_pkg::OFF_DIRECTION)
                               |-> WB_DAT_O[4:2] == st_r.dir)
    else $error("direction readback wrong");
  dir_write_a: assert property (wr_dir |=> st_r.dir == $past(WB_DAT_I[4:2]))
    else $error("direction write lost");
  od_two_write_a: assert property (wr && reg_hit(WB_ADR_I, pgm_pkg::OFF_OD_TWO)
                                   |=> st_r.od_two == $past(WB_DAT_I[7:0]))
    else $error("open-drain write lost");
  reset_state_a: assert property (!$past(RESETN) |-> st_r.dir == pgm_pkg::RST_DIRECTION
                                  && st_r.lat == pgm_pkg::RST_LATCH && !WB_ACK_O)
    else $error("latch or direction wrong after reset");
  clear_en_reset_a: assert property (!$past(RESETN) |-> st_r.ctrl == pgm_pkg::RST_CONTROL)
    else $error("master clear not enabled after reset");
  pin_five_in_a: assert property (PIN_OE_N[5] && !PIN_OUT[5])
    else $error("pin five driven");
  // analog select only cuts the digital input; the driver stays
  analog_keeps_drive_a: assert property (ana_mask[3] && !st_r.dir[3] && !CMP_FOUR_EN && !EPWM_THREE_D_EN
                                         |-> !PIN_OE_N[3] && PIN_OUT[3] == st_r.lat[3])
    else $error("analog select disturbed pin three drive");
  analog_mask_a: assert property (ana_mask[4] |=> !TIMER_SEVEN_CLK && !CMP_FIVE_CAPTURE)
    else $error("analog pin four reached digital inputs");
  timer_any_dir_a: assert property (!ana_mask[4] |=> TIMER_SEVEN_CLK == $past(pin_lvl[4])
                                    && TIMER_FIVE_GATE == $past(pin_lvl[4]))
    else $error("timer inputs do not follow pin four");
  rx_dir_zero_a: assert property (!st_r.dir[2] |=> !SER_ASYNC_RX)
    else $error("receive data while pin two drives");
  cap_four_zero_a: assert property (!st_r.dir[3] |=> !CMP_FOUR_CAPTURE)
    else $error("capture four while pin three drives");
  cap_five_zero_a: assert property (!st_r.dir[4] |=> !CMP_FIVE_CAPTURE)
    else $error("capture five while pin four drives");
  cap_four_follow_a: assert property (st_r.dir[3] && !ana_mask[3]
                                      |=> CMP_FOUR_CAPTURE == $past(pin_lvl[3]))
    else $error("capture four does not follow pin three");

  port_write_c: cover property (wr_port);
  port_read_c:  cover property (rd_ack && reg_hit(WB_ADR_I, pgm_pkg::OFF_PIN_LEVELS) && WB_DAT_O[2]);
  rx_rise_c:    cover property ($rose(SER_ASYNC_RX));
endmodule

/* common/pgm_pkg.sv */
// package: register map, reset values and field positions of the port g pin mux
// What this block does
// - each of pins two to four has latch and direction bit; 0 drives latch, 1 is input
// - compare and serial outputs get open-drain per function from od registers
// - pin two feeds asynchronous serial receive when its direction bit is 1
// - synchronous serial data output drives pin two over the latch
// - compare/pwm output overrides latch on pins three, four when direction 0
// - analog select set after reset; it never disturbs the output driver
// - clock-calendar out, timer clock and gate on pin four ignore direction
// - enhanced pwm outputs on pins three, four may tri-state on shutdown
// - unimplemented bits of port, direction and open-drain registers read 0
// - port bit five exists only while master clear pin enable is 0
package pgm_pkg;
  // ==========================================
  // register byte offsets
  localparam logic [7:0] OFF_PIN_LEVELS    = 8'h00;
  localparam logic [7:0] OFF_DIRECTION     = 8'h04;
  localparam logic [7:0] OFF_OUTPUT_LATCH  = 8'h08;
  localparam logic [7:0] OFF_ANALOG_SELECT = 8'h0c;
  localparam logic [7:0] OFF_OD_ONE        = 8'h10;
  localparam logic [7:0] OFF_OD_TWO        = 8'h14;
  localparam logic [7:0] OFF_OD_THREE      = 8'h18;
  localparam logic [7:0] OFF_CONTROL       = 8'h1c;
  // ==========================================
  // values after reset
  localparam logic [4:2] RST_LATCH         = 3'h0;
  localparam logic [4:2] RST_DIRECTION     = 3'h7;
  localparam logic [7:0] RST_ANALOG_SELECT = 8'hff;
  localparam logic [7:0] RST_OD            = 8'h00;
  localparam logic [2:0] RST_CONTROL       = 3'h1;
  // ==========================================
  // implemented bits of the open-drain registers
  localparam logic [7:0] MASK_OD_ONE       = 8'he1;
  localparam logic [7:0] MASK_OD_TWO       = 8'hff;
  localparam logic [7:0] MASK_OD_THREE     = 8'hc1;
  // ==========================================
  // field positions
  localparam int POS_ANALOG_SIXTEEN   = 0;
  localparam int POS_ANALOG_SEVENTEEN = 1;
  localparam int POS_ANALOG_EIGHTEEN  = 2;
  localparam int POS_COMPARE_FOUR_OD  = 1;
  localparam int POS_COMPARE_FIVE_OD  = 2;
  localparam int POS_SERIAL_TWO_OD    = 7;
  localparam int POS_MASTER_CLEAR_EN  = 0;
  localparam int POS_PWM_THREE_TRI    = 1;
  localparam int POS_PWM_ONE_TRI      = 2;
  localparam int POS_PIN_FIVE         = 5;
endpackage

/* common/pgm_pin_if.sv */
// interface carrying pin configuration to the pin mux and pin drive back
`timescale 1ns/1ns
interface pgm_pin_if;
  logic [4:2] lat;
  logic [4:2] dir;
  logic       od_serial;
  logic       od_cmp_four;
  logic       od_cmp_five;
  logic       tri_pwm_three;
  logic       tri_pwm_one;
  logic [5:2] pin_out;
  logic [5:2] pin_oe_n;
  modport cfg (output lat, dir, od_serial, od_cmp_four, od_cmp_five, tri_pwm_three, tri_pwm_one,
               input pin_out, pin_oe_n);
  modport mux (input lat, dir, od_serial, od_cmp_four, od_cmp_five, tri_pwm_three, tri_pwm_one,
               output pin_out, pin_oe_n);
endinterface

/* core/pgm_sync.sv */
// three-stage pin input synchroniser with agreement filter
`timescale 1ns/1ns
module pgm_sync (
  input  wire logic       clk,    // system clock
  input  wire logic       resetn, // synchronous reset, active low
  input  wire logic [5:2] d,      // raw pin levels
  output logic      [5:2] q       // filtered levels
);
  typedef struct packed {
    logic [5:2] s1;
    logic [5:2] s2;
    logic [5:2] s3;
    logic [5:2] q;
  } pgm_sync_state_type;

  pgm_sync_state_type st_r;
  pgm_sync_state_type st_nxt;

  // s1 is read only by s2; a level counts once s2 and s3 agree
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 2; i <= 5; i++) begin
      if (st_r.s2[i] == st_r.s3[i]) begin
        st_nxt.q[i] = st_r.s2[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.q;
endmodule

/* core/pgm_pin_mux.sv */
// output selection and drive enables for pins two to five
`timescale 1ns/1ns
module pgm_pin_mux (
  input  wire logic clk,           // clock for assertions only
  input  wire logic resetn,        // reset for assertions only
  pgm_pin_if.mux    pif,           // configuration in, pin drive out
  input  wire logic ser_sync_en,   // synchronous serial transmit active
  input  wire logic ser_sync_data, // synchronous serial data
  input  wire logic cmp_four_en,   // compare/pwm four active
  input  wire logic cmp_four,      // compare/pwm four level
  input  wire logic cmp_five_en,   // compare/pwm five active
  input  wire logic cmp_five,      // compare/pwm five level
  input  wire logic pwm_three_en,  // enhanced pwm three output d active
  input  wire logic pwm_three,     // enhanced pwm three output d level
  input  wire logic pwm_one_en,    // enhanced pwm one output d active
  input  wire logic pwm_one,       // enhanced pwm one output d level
  input  wire logic pwm_shutdown,  // enhanced pwm shutdown event
  input  wire logic cal_en,        // clock-calendar output active
  input  wire logic cal_out        // clock-calendar output level
);
  // returns {level, oe_n}; open drain releases the pin for a high
  function automatic logic [1:0] pin_drive(input logic data, input logic od);
    return (od && data) ? 2'b01 : {data, 1'b0};
  endfunction

  logic [1:0] d2;
  logic [1:0] d3;
  logic [1:0] d4;

  always_comb begin
    if (ser_sync_en) begin
      d2 = pin_drive(ser_sync_data, pif.od_serial);
    end else if (!pif.dir[2]) begin
      d2 = pin_drive(pif.lat[2], 1'b0);
    end else begin
      d2 = 2'b01;
    end
    if (pif.dir[3]) begin
      d3 = 2'b01;
    end else if (cmp_four_en) begin
      d3 = pin_drive(cmp_four, pif.od_cmp_four);
    end else if (pwm_three_en) begin
      d3 = (pwm_shutdown && pif.tri_pwm_three) ? 2'b01 : pin_drive(pwm_three, 1'b0);
    end else begin
      d3 = pin_drive(pif.lat[3], 1'b0);
    end
    if (cal_en) begin
      d4 = pin_drive(cal_out, 1'b0);
    end else if (pif.dir[4]) begin
      d4 = 2'b01;
    end else if (cmp_five_en) begin
      d4 = pin_drive(cmp_five, pif.od_cmp_five);
    end else if (pwm_one_en) begin
      d4 = (pwm_shutdown && pif.tri_pwm_one) ? 2'b01 : pin_drive(pwm_one, 1'b0);
    end else begin
      d4 = pin_drive(pif.lat[4], 1'b0);
    end
  end

  // latch drives when direction 0; pin five is input only
  assign pif.pin_out  = {1'b0, d4[1], d3[1], d2[1]};
  assign pif.pin_oe_n = {1'b1, d4[0], d3[0], d2[0]};

  // ==========================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  dir_drive_a: assert property (!pif.dir[2] && !ser_sync_en |-> !pif.pin_oe_n[2] && pif.pin_out[2] == pif.lat[2])
    else $error("pin two not driven from latch");
  od_compare_a: assert property (!pif.dir[3] && cmp_four_en && pif.od_cmp_four && cmp_four |-> pif.pin_oe_n[3])
    else $error("open-drain high not released");
  sync_tx_a: assert property (ser_sync_en && !pif.od_serial |-> !pif.pin_oe_n[2] && pif.pin_out[2] == ser_sync_data)
    else $error("serial data does not drive pin two");
  cmp_override_a: assert property (!pif.dir[4] && !cal_en && cmp_five_en && !pif.od_cmp_five
                                   |-> !pif.pin_oe_n[4] && pif.pin_out[4] == cmp_five)
    else $error("compare five does not override latch");
  cal_any_dir_a: assert property (cal_en |-> !pif.pin_oe_n[4] && pif.pin_out[4] == cal_out)
    else $error("calendar output blocked by direction");
  pwm_tristate_a: assert property (!pif.dir[3] && !cmp_four_en && pwm_three_en && pwm_shutdown
                                   && pif.tri_pwm_three |-> pif.pin_oe_n[3])
    else $error("pwm not tri-stated on shutdown");

  sync_tx_c: cover property (ser_sync_en && !pif.pin_oe_n[2]);
  pwm_tri_c: cover property (pwm_shutdown && pwm_three_en && pif.pin_oe_n[3]);
endmodule

/* tb/pgm_pin_model.sv */
// board model: resolves pad levels from the block drive and an outside source
`timescale 1ns/1ns
module pgm_pin_model (
  input  wire logic [5:2] pin_out,  // block drive level
  input  wire logic [5:2] pin_oe_n, // low while the block drives
  input  wire logic [5:2] ext_en,   // outside source drives
  input  wire logic [5:2] ext_val,  // outside source level
  output logic      [5:2] pin_lvl   // resolved pad level
);
  // released pads float high through board pull-ups, never hold a stale value
  always_comb begin
    for (int i = 2; i <= 5; i++) begin
      pin_lvl[i] = !pin_oe_n[i] ? pin_out[i] : (ext_en[i] ? ext_val[i] : 1'b1);
    end
  end
endmodule

/* tb/pgm_top_tb_top.sv */
// self-checking bench for the port g upper pin mux
`timescale 1ns/1ns
module pgm_top_tb_top;
  logic        core_clk = 1'b0;
  logic        resetn   = 1'b0;
  logic [7:0]  adr      = 8'h00;
  logic [31:0] wdat     = 32'h0;
  logic [31:0] dat_o;
  logic [31:0] rd;
  logic        we       = 1'b0;
  logic        cyc      = 1'b0;
  logic        stb      = 1'b0;
  logic        ack;
  logic [3:0]  sel      = 4'h0;
  // peripheral lines: sync en/data, cmp4 en/out, cmp5 en/out, pwm3 en/d, pwm1 en/d, shutdown, cal en/out
  logic [12:0] pv       = 13'h0;
  logic [5:2]  ext_en   = 4'h0;
  logic [5:2]  ext_val  = 4'h0;
  logic [5:2]  pin_lvl, pin_out, pin_oe_n;
  logic        rx, cap4, cap5, t7, t5g;
  logic [4:2]  asel;
  int          n_errors = 0;
  int          n_tests  = 0;
  int          cycles   = 0;

  always #5 core_clk = ~core_clk;

  pgm_top DUT (
    .CORE_CLK(core_clk), .RESETN(resetn), .WB_ADR_I(adr), .WB_DAT_I(wdat), .WB_DAT_O(dat_o),
    .WB_WE_I(we), .WB_SEL_I(sel), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_ACK_O(ack),
    .PIN_IN(pin_lvl), .PIN_OUT(pin_out), .PIN_OE_N(pin_oe_n),
    .SER_SYNC_TX_EN(pv[0]), .SER_SYNC_DATA(pv[1]), .CMP_FOUR_EN(pv[2]), .CMP_FOUR_OUT(pv[3]),
    .CMP_FIVE_EN(pv[4]), .CMP_FIVE_OUT(pv[5]), .EPWM_THREE_D_EN(pv[6]), .EPWM_THREE_D(pv[7]),
    .EPWM_ONE_D_EN(pv[8]), .EPWM_ONE_D(pv[9]), .EPWM_SHUTDOWN(pv[10]),
    .CLOCK_CAL_EN(pv[11]), .CLOCK_CAL_OUT(pv[12]),
    .SER_ASYNC_RX(rx), .CMP_FOUR_CAPTURE(cap4), .CMP_FIVE_CAPTURE(cap5),
    .TIMER_SEVEN_CLK(t7), .TIMER_FIVE_GATE(t5g), .ANALOG_SEL(asel)
  );

  pgm_pin_model board (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_en(ext_en), .ext_val(ext_val), .pin_lvl(pin_lvl));

  // ==========================================
  // helpers
  task automatic final_report();
    $display("errors=%0d tests=%0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      final_report();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // classic cycle: request held until ack is sampled, then one idle cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge core_clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= s;
    do @(posedge core_clk); while (ack !== 1'b1);
    rd = dat_o;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d, 4'h1);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0, 4'h1);
    chk(rd, exp);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic setp(input logic [12:0] v, input logic [5:2] e, input logic [5:2] l);
    @(posedge core_clk);
    pv <= v; ext_en <= e; ext_val <= l;
    tick(1);
  endtask

  // ==========================================
  // scenarios
  task automatic t_reset();
    chk({pin_oe_n, pin_out, asel}, {4'hf, 4'h0, 3'h7});
    rdc(pgm_pkg::OFF_DIRECTION, 32'h1c);
    rdc(pgm_pkg::OFF_ANALOG_SELECT, 32'hff);
    rdc(pgm_pkg::OFF_PIN_LEVELS, 32'h0);
    rdc(pgm_pkg::OFF_OD_TWO, 32'h0);
    rdc(pgm_pkg::OFF_CONTROL, 32'h01);
  endtask

  task automatic t_regs();
    wr(pgm_pkg::OFF_DIRECTION, 32'hff);
    rdc(pgm_pkg::OFF_DIRECTION, 32'h1c);
    wr(pgm_pkg::OFF_OD_ONE, 32'hff);
    rdc(pgm_pkg::OFF_OD_ONE, 32'he1);
    wr(pgm_pkg::OFF_OD_THREE, 32'hff);
    rdc(pgm_pkg::OFF_OD_THREE, 32'hc1);
    wr(pgm_pkg::OFF_OD_ONE, 32'h0);
    wr(pgm_pkg::OFF_OD_THREE, 32'h0);
    // a write without lane 0 is acked but dropped
    wb(1'b1, pgm_pkg::OFF_DIRECTION, 32'h0, 4'h0);
    rdc(pgm_pkg::OFF_DIRECTION, 32'h1c);
    rdc(8'h20, 32'h0);
  endtask

  task automatic t_latch();
    wr(pgm_pkg::OFF_OUTPUT_LATCH, 32'h14);
    wr(pgm_pkg::OFF_DIRECTION, 32'h0);
    tick(1);
    chk({pin_oe_n, pin_out}, {4'h8, 4'h5});
    rdc(pgm_pkg::OFF_OUTPUT_LATCH, 32'h14);
    wr(pgm_pkg::OFF_PIN_LEVELS, 32'h08);
    tick(1);
    chk(pin_out, 4'h2);
  endtask

  task automatic t_inputs();
    wr(pgm_pkg::OFF_DIRECTION, 32'h1c);
    wr(pgm_pkg::OFF_ANALOG_SELECT, 32'h0);
    setp(13'h0, 4'hf, 4'h5);
    tick(8);
    chk(asel, 3'h0);
    rdc(pgm_pkg::OFF_PIN_LEVELS, 32'h14);
    chk({rx, cap4, cap5, t7, t5g}, 5'h17);
    wr(pgm_pkg::OFF_ANALOG_SELECT, 32'h01);
    rdc(pgm_pkg::OFF_PIN_LEVELS, 32'h04);
    chk(asel, 3'h4);
    wr(pgm_pkg::OFF_ANALOG_SELECT, 32'h0);
    wr(pgm_pkg::OFF_CONTROL, 32'h0);
    setp(13'h0, 4'hf, 4'hd);
    tick(8);
    rdc(pgm_pkg::OFF_PIN_LEVELS, 32'h34);
    wr(pgm_pkg::OFF_CONTROL, 32'h1);
    rdc(pgm_pkg::OFF_PIN_LEVELS, 32'h14);
    setp(13'h0, 4'h0, 4'h0);
    wr(pgm_pkg::OFF_OUTPUT_LATCH, 32'h10);
    wr(pgm_pkg::OFF_DIRECTION, 32'h0c);
    tick(8);
    chk({t7, t5g, cap5, rx, cap4}, 5'h1b);
    rdc(pgm_pkg::OFF_PIN_LEVELS, 32'h1c);
  endtask

  task automatic t_over();
    wr(pgm_pkg::OFF_OUTPUT_LATCH, 32'h0);
    wr(pgm_pkg::OFF_DIRECTION, 32'h0);
    setp(13'h0003, 4'h0, 4'h0);
    chk({pin_oe_n[2], pin_out[2]}, 2'b01);
    setp(13'h000c, 4'h0, 4'h0);
    chk({pin_oe_n[3], pin_out[3]}, 2'b01);
    setp(13'h07c0, 4'h0, 4'h0);
    chk({pin_oe_n[4:3], pin_out[4:3]}, 4'h3);
    wr(pgm_pkg::OFF_CONTROL, 32'h07);
    tick(1);
    chk(pin_oe_n[4:3], 2'b11);
    setp(13'h03c0, 4'h0, 4'h0);
    chk({pin_oe_n[4:3], pin_out[4:3]}, 4'h3);
    wr(pgm_pkg::OFF_DIRECTION, 32'h10);
    setp(13'h1800, 4'h0, 4'h0);
    chk({pin_oe_n[4], pin_out[4]}, 2'b01);
    wr(pgm_pkg::OFF_OD_TWO, 32'h02);
    wr(pgm_pkg::OFF_OD_THREE, 32'h80);
    setp(13'h000f, 4'h0, 4'h0);
    chk(pin_oe_n[3:2], 2'b11);
    setp(13'h0005, 4'h0, 4'h0);
    chk({pin_oe_n[3:2], pin_out[3:2]}, 4'h0);
    rdc(pgm_pkg::OFF_DIRECTION, 32'h10);
  endtask

  initial begin
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    t_reset();
    t_regs();
    t_latch();
    t_inputs();
    t_over();
    final_report();
  end
endmodule
